/* pkg/loop_det_defs.svh */
// Constants for the loop detector output logic: widths, register map, timing
`ifndef LOOP_DET_DEFS_SVH
`define LOOP_DET_DEFS_SVH

// Sizes
`define LD_NCH        4
`define LD_NOUT       4
`define LD_NVIN       4
`define LD_TW         8
`define LD_MAPW       9
`define LD_DW         16
`define LD_AW         8
`define LD_TICKW      22

// Map word layout: loops [3:0], isolated inputs [7:4], health [8]
`define LD_MAP_LOOP_LSB  0
`define LD_MAP_VIN_LSB   4
`define LD_MAP_HEALTH    8

// Register addresses
`define LD_A_MODE_CMD   8'h00
`define LD_A_STATUS     8'h01
`define LD_A_OUTS       8'h02
`define LD_A_DLY_BASE   8'h10
`define LD_A_EXT_BASE   8'h14
`define LD_A_PMAP_BASE  8'h18
`define LD_A_AMAP_BASE  8'h1c

// Mode command word fields
`define LD_CMD_CH_LSB   0
`define LD_CMD_CH_MSB   1
`define LD_CMD_OPT_BIT  2
`define LD_CMD_VAL_BIT  3
`define LD_OPT_ISLAND   1'b0
`define LD_OPT_PAIR     1'b1

// Timer tick: period in ms, clock in kHz
`define LD_TICK_MS      100
`define LD_CLK_KHZ      40000

`endif

/* pkg/loop_det_pkg.sv */
// Types for the loop detector output logic
`default_nettype none
`include "loop_det_defs.svh"
package loop_det_pkg;

	// Crossing island sequence
	typedef enum logic [1:0] {ISL_IDLE, ISL_ENTER, ISL_LEAVE} isl_st_e;

	// Paired direction sequence, per pair
	typedef enum logic [2:0] {PR_IDLE, PR_FIRST_LO, PR_FIRST_HI, PR_CALL_LO, PR_CALL_HI} pair_st_e;

	// Whole state of the block
	typedef struct packed {
		logic                                  island_en;
		logic [1:0]                            pair_en;
		isl_st_e                               isl;
		logic                                  isl_from_hi;
		pair_st_e [1:0]                        pst;
		logic [`LD_NOUT-1:0][`LD_TW-1:0]       dly_set;
		logic [`LD_NOUT-1:0][`LD_TW-1:0]       ext_set;
		logic [`LD_NOUT-1:0][`LD_TW-1:0]       dly_cnt;
		logic [`LD_NOUT-1:0][`LD_TW-1:0]       ext_cnt;
		logic [`LD_NOUT-1:0][`LD_MAPW-1:0]     pmap;
		logic [`LD_NOUT-1:0][`LD_MAPW-1:0]     amap;
		logic [`LD_NOUT-1:0]                   off;
		logic [`LD_NOUT-1:0]                   call_q;
		logic [`LD_NOUT-1:0]                   aux;
		logic [`LD_NCH-1:0]                    ccall;
		logic [`LD_TICKW-1:0]                  tick_cnt;
		logic                                  buzz;
		logic [`LD_DW-1:0]                     rdata;
	} state_s;

endpackage : loop_det_pkg
`default_nettype wire

/* rtl/loop_detector_output_logic.sv */
// Occupancy modes, output timers and input/output mapping of the loop detector
`default_nettype none
`include "loop_det_defs.svh"

module loop_detector_output_logic #(
	parameter int TICK_CYCLES = `LD_TICK_MS * `LD_CLK_KHZ
) (
	// Clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    resetn,
	// Register port
	input  wire logic [`LD_AW-1:0]       reg_addr,
	input  wire logic [`LD_DW-1:0]       reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic      [`LD_DW-1:0]       reg_rdata,
	// Loop front end and isolated inputs
	input  wire logic [`LD_NCH-1:0]      loop_present,
	input  wire logic [`LD_NCH-1:0]      loop_fail,
	input  wire logic [`LD_NVIN-1:0]     vital_in,
	input  wire logic                    health_ok,
	// Outputs to the controller
	output logic      [`LD_NOUT-1:0]     prim_out,
	output logic      [`LD_NOUT-1:0]     aux_out,
	output logic                         island_active,
	output logic                         warn_buzz
);

	loop_det_pkg::state_s st_r;
	loop_det_pkg::state_s st_nxt;

	logic [`LD_NCH-1:0]  loop_call;
	logic [`LD_NOUT-1:0] src_p;
	logic [`LD_NOUT-1:0] src_a;
	logic                tick;

	// OR of every source selected by a map word
	function automatic logic map_or(input logic [`LD_MAPW-1:0] m, input logic [`LD_NCH-1:0] lc,
		input logic [`LD_NVIN-1:0] vi, input logic hf);
		return |(m & {hf, vi, lc});
	endfunction : map_or

	// Hit on a block of four word registers
	function automatic logic in_block(input logic [`LD_AW-1:0] a, input logic [`LD_AW-1:0] base);
		return a[`LD_AW-1:2] == base[`LD_AW-1:2];
	endfunction : in_block

	// Next state
	always_comb begin
		logic [1:0] ch;
		logic       opp;
		logic       pl;
		logic       ph;
		logic       fl;
		int         lo;
		ch  = reg_wdata[`LD_CMD_CH_MSB:`LD_CMD_CH_LSB];
		opp = 1'b0;
		pl  = 1'b0;
		ph  = 1'b0;
		fl  = 1'b0;
		lo  = 0;
		st_nxt      = st_r;
		st_nxt.buzz = 1'b0;
		st_nxt.rdata = '0;

		// Free-running 100 ms tick
		tick = st_r.tick_cnt == `LD_TICKW'(TICK_CYCLES - 1);
		st_nxt.tick_cnt = tick ? '0 : st_r.tick_cnt + `LD_TICKW'(1);

		// Register writes
		if (reg_wr) begin
			if (reg_addr == `LD_A_MODE_CMD) begin
				if (reg_wdata[`LD_CMD_OPT_BIT] == `LD_OPT_ISLAND) begin
					// Channel number ignored: one setting for all channels
					if (!reg_wdata[`LD_CMD_VAL_BIT])
						st_nxt.island_en = 1'b0;
					else if (|st_r.pair_en)
						st_nxt.buzz = 1'b1;
					else
						st_nxt.island_en = 1'b1;
				end else begin
					// Both members of the pair share one bit
					if (!reg_wdata[`LD_CMD_VAL_BIT])
						st_nxt.pair_en[ch[1]] = 1'b0;
					else if (st_r.island_en)
						st_nxt.buzz = 1'b1;
					else
						st_nxt.pair_en[ch[1]] = 1'b1;
				end
			end else if (in_block(reg_addr, `LD_A_DLY_BASE)) begin
				st_nxt.dly_set[reg_addr[1:0]] = reg_wdata[`LD_TW-1:0];
			end else if (in_block(reg_addr, `LD_A_EXT_BASE)) begin
				st_nxt.ext_set[reg_addr[1:0]] = reg_wdata[`LD_TW-1:0];
			end else if (in_block(reg_addr, `LD_A_PMAP_BASE)) begin
				st_nxt.pmap[reg_addr[1:0]] = reg_wdata[`LD_MAPW-1:0];
				st_nxt.pmap[reg_addr[1:0]][`LD_MAP_HEALTH] = 1'b0;
			end else if (in_block(reg_addr, `LD_A_AMAP_BASE)) begin
				st_nxt.amap[reg_addr[1:0]] = reg_wdata[`LD_MAPW-1:0];
			end
		end

		// Plain channel calls; a failed loop calls for safety
		loop_call = loop_present | loop_fail;

		// Paired direction, pairs 1/2 and 3/4
		for (int p = 0; p < 2; p++) begin
			lo = 2 * p;
			pl = loop_present[lo];
			ph = loop_present[lo + 1];
			fl = loop_fail[lo] | loop_fail[lo + 1];
			if (!st_r.pair_en[p]) begin
				st_nxt.pst[p] = loop_det_pkg::PR_IDLE;
			end else begin
				case (st_r.pst[p])
					loop_det_pkg::PR_IDLE: begin
						if (pl && !ph)
							st_nxt.pst[p] = loop_det_pkg::PR_FIRST_LO;
						else if (ph && !pl)
							st_nxt.pst[p] = loop_det_pkg::PR_FIRST_HI;
					end
					loop_det_pkg::PR_FIRST_LO: begin
						if (!pl)
							st_nxt.pst[p] = loop_det_pkg::PR_IDLE;
						else if (ph)
							st_nxt.pst[p] = loop_det_pkg::PR_CALL_HI;
					end
					loop_det_pkg::PR_FIRST_HI: begin
						if (!ph)
							st_nxt.pst[p] = loop_det_pkg::PR_IDLE;
						else if (pl)
							st_nxt.pst[p] = loop_det_pkg::PR_CALL_LO;
					end
					loop_det_pkg::PR_CALL_LO,
					loop_det_pkg::PR_CALL_HI: begin
						// Held until both loops are clear
						if (!pl && !ph)
							st_nxt.pst[p] = loop_det_pkg::PR_IDLE;
					end
					default: st_nxt.pst[p] = loop_det_pkg::PR_IDLE;
				endcase
				// Only the last channel calls, or both on a loop failure; timers downstream unchanged
				loop_call[lo]     = fl | (st_r.pst[p] == loop_det_pkg::PR_CALL_LO);
				loop_call[lo + 1] = fl | (st_r.pst[p] == loop_det_pkg::PR_CALL_HI);
			end
		end

		// Crossing island; arming loops on channels 1 and 3
		opp = st_r.isl_from_hi ? loop_present[0] : loop_present[2];
		if (!st_r.island_en) begin
			st_nxt.isl = loop_det_pkg::ISL_IDLE;
		end else begin
			case (st_r.isl)
				loop_det_pkg::ISL_IDLE: begin
					if (loop_present[0] || loop_present[2]) begin
						st_nxt.isl         = loop_det_pkg::ISL_ENTER;
						st_nxt.isl_from_hi = !loop_present[0];
					end
				end
				loop_det_pkg::ISL_ENTER: begin
					// A vehicle that backs off every loop ends the sequence
					if (opp)
						st_nxt.isl = loop_det_pkg::ISL_LEAVE;
					else if (!(|loop_present))
						st_nxt.isl = loop_det_pkg::ISL_IDLE;
				end
				loop_det_pkg::ISL_LEAVE: begin
					if (!opp)
						st_nxt.isl = loop_det_pkg::ISL_IDLE;
				end
				default: st_nxt.isl = loop_det_pkg::ISL_IDLE;
			endcase
			// Main loops only call while armed or when failed
			loop_call[1] = loop_fail[1] | (loop_present[1] && st_r.isl != loop_det_pkg::ISL_IDLE);
			loop_call[3] = loop_fail[3] | (loop_present[3] && st_r.isl != loop_det_pkg::ISL_IDLE);
		end
		st_nxt.ccall = loop_call;

		// Output conditioning per output
		for (int j = 0; j < `LD_NOUT; j++) begin
			src_p[j] = map_or(st_r.pmap[j], loop_call, vital_in, !health_ok);
			src_a[j] = map_or(st_r.amap[j], loop_call, vital_in, !health_ok);
			st_nxt.call_q[j] = src_p[j];
			if (src_p[j] && !st_r.call_q[j]) begin
				st_nxt.dly_cnt[j] = st_r.dly_set[j];
				st_nxt.ext_cnt[j] = '0;
			end else if (src_p[j]) begin
				if (st_r.dly_cnt[j] == '0)
					st_nxt.off[j] = 1'b1;
				else if (tick)
					st_nxt.dly_cnt[j] = st_r.dly_cnt[j] - `LD_TW'(1);
			end else if (st_r.call_q[j]) begin
				// Call gone: a call that never got through the delay is dropped
				st_nxt.dly_cnt[j] = '0;
				if (st_r.off[j])
					st_nxt.ext_cnt[j] = st_r.ext_set[j];
			end else if (st_r.ext_cnt[j] == '0) begin
				st_nxt.off[j] = 1'b0;
			end else if (tick) begin
				st_nxt.ext_cnt[j] = st_r.ext_cnt[j] - `LD_TW'(1);
			end
			// Auxiliary path bypasses both timers
			st_nxt.aux[j] = !src_a[j];
		end
		if (st_nxt.isl != loop_det_pkg::ISL_IDLE)
			st_nxt.aux[0] = 1'b0;

		// Register reads, data valid in the following cycle
		if (reg_rd) begin
			if (reg_addr == `LD_A_STATUS)
				st_nxt.rdata = `LD_DW'({st_r.ccall, st_r.isl != loop_det_pkg::ISL_IDLE, st_r.pair_en,
					st_r.island_en});
			else if (reg_addr == `LD_A_OUTS)
				st_nxt.rdata = `LD_DW'({st_r.aux, ~st_r.off});
			else if (in_block(reg_addr, `LD_A_DLY_BASE))
				st_nxt.rdata = `LD_DW'(st_r.dly_set[reg_addr[1:0]]);
			else if (in_block(reg_addr, `LD_A_EXT_BASE))
				st_nxt.rdata = `LD_DW'(st_r.ext_set[reg_addr[1:0]]);
			else if (in_block(reg_addr, `LD_A_PMAP_BASE))
				st_nxt.rdata = `LD_DW'(st_r.pmap[reg_addr[1:0]]);
			else if (in_block(reg_addr, `LD_A_AMAP_BASE))
				st_nxt.rdata = `LD_DW'(st_r.amap[reg_addr[1:0]]);
		end
	end

	// State register; all timers and modes clear on reset
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// Outputs straight from the state register
	assign reg_rdata     = st_r.rdata;
	assign prim_out      = ~st_r.off;
	assign aux_out       = st_r.aux;
	assign island_active = st_r.isl != loop_det_pkg::ISL_IDLE;
	assign warn_buzz     = st_r.buzz;

	// Checks
	logic cmd_island_on;
	logic cmd_pair_on;
	assign cmd_island_on = reg_wr && reg_addr == `LD_A_MODE_CMD && reg_wdata[`LD_CMD_VAL_BIT]
		&& reg_wdata[`LD_CMD_OPT_BIT] == `LD_OPT_ISLAND;
	assign cmd_pair_on = reg_wr && reg_addr == `LD_A_MODE_CMD && reg_wdata[`LD_CMD_VAL_BIT]
		&& reg_wdata[`LD_CMD_OPT_BIT] == `LD_OPT_PAIR;

	sequence s_call_held(int j);
		src_p[j] && st_r.call_q[j] && !st_r.off[j] && st_r.dly_cnt[j] == '0;
	endsequence

	sequence s_ext_running(int j);
		!src_p[j] && !st_r.call_q[j] && st_r.off[j] && st_r.ext_cnt[j] != '0;
	endsequence

	chk_modes_exclusive: assert property (@(posedge sys_clk) disable iff (!resetn)
		!(st_r.island_en && |st_r.pair_en))
		else $error("island and paired modes both on");

	chk_refuse_buzz: assert property (@(posedge sys_clk) disable iff (!resetn)
		cmd_pair_on && st_r.island_en |=> warn_buzz && $stable(st_r.pair_en))
		else $error("paired request during island mode not refused");

	chk_island_global: assert property (@(posedge sys_clk) disable iff (!resetn)
		cmd_island_on && !(|st_r.pair_en) |=> st_r.island_en)
		else $error("island mode not set from a channel");

	chk_pair_partner: assert property (@(posedge sys_clk) disable iff (!resetn)
		cmd_pair_on && !st_r.island_en |=> st_r.pair_en[$past(reg_wdata[`LD_CMD_CH_MSB])])
		else $error("pair setting not shared by partner");

	chk_island_aux1: assert property (@(posedge sys_clk) disable iff (!resetn)
		island_active |-> !aux_out[0])
		else $error("aux 1 active during island presence");

	chk_island_end: assert property (@(posedge sys_clk) disable iff (!resetn)
		st_r.isl == loop_det_pkg::ISL_LEAVE && st_r.island_en && !loop_present[0] && !loop_present[2]
		|=> !island_active)
		else $error("island presence did not end");

	chk_first_nocall: assert property (@(posedge sys_clk) disable iff (!resetn)
		st_r.pair_en[0] && st_r.pst[0] == loop_det_pkg::PR_FIRST_LO && !loop_fail[0] && !loop_fail[1]
		|-> !loop_call[0] && !loop_call[1])
		else $error("first channel of pair called");

	chk_pair_fail: assert property (@(posedge sys_clk) disable iff (!resetn)
		st_r.pair_en[0] && (loop_fail[0] || loop_fail[1]) |-> loop_call[0] && loop_call[1])
		else $error("failed pair not calling on both channels");

	chk_delay_expire: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_call_held(0) |=> st_r.off[0])
		else $error("primary output not dropped at delay end");

	chk_ext_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_ext_running(0) ##0 !src_p[0] |=> !prim_out[0])
		else $error("primary output restored during extension");

	chk_health_prim: assert property (@(posedge sys_clk) disable iff (!resetn)
		reg_wr && in_block(reg_addr, `LD_A_PMAP_BASE) |=> st_r.pmap[$past(reg_addr[1:0])][`LD_MAP_HEALTH] == 1'b0)
		else $error("health mapped to a primary output");

endmodule : loop_detector_output_logic
`default_nettype wire

/* test/ctrl_model.sv */
// Controller side model: watches primary output 1 and counts its drops
`default_nettype none
`include "loop_det_defs.svh"
module ctrl_model (
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                resetn,
	// Outputs seen from the detector
	input  wire logic [`LD_NOUT-1:0] prim_out,
	output logic      [15:0]         n_drop0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_r;

	// Count each deactivation of primary output 1; a glitch shows as an extra drop
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			last_r  <= 1'b1;
			n_drop0 <= 16'h0000;
		end else begin
			last_r <= prim_out[0];
			if (last_r && !prim_out[0])
				n_drop0 <= n_drop0 + 16'h0001;
		end
	end
endmodule : ctrl_model
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the loop detector output logic
`default_nettype none
`include "loop_det_defs.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic [3:0]  lp = 4'h0;
	logic [3:0]  lf = 4'h0;
	logic [3:0]  vin = 4'h0;
	logic        hok = 1'b1;
	logic [3:0]  prim_out;
	logic [3:0]  aux_out;
	logic        island_active;
	logic        warn_buzz;
	logic [15:0] n_drop0;
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          n_cyc = 0;
	logic        seen;

	loop_detector_output_logic #(.TICK_CYCLES(4)) u_loop_detector_output_logic (
		.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .loop_present(lp),
		.loop_fail(lf), .vital_in(vin), .health_ok(hok), .prim_out(prim_out),
		.aux_out(aux_out), .island_active(island_active), .warn_buzz(warn_buzz));
	ctrl_model u_ctrl_model (.sys_clk(sys_clk), .resetn(resetn), .prim_out(prim_out), .n_drop0(n_drop0));

	// 40 MHz clock
	always #12.5 sys_clk = ~sys_clk;

	// Hang guard: the tests need well under 3000 cycles
	always @(posedge sys_clk) begin
		n_cyc = n_cyc + 1;
		if (n_cyc == 6000) begin
			n_mismatch = n_mismatch + 1;
			$display("BAD %0t timeout", $time);
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// Wait n edges, then sample just after the last one
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp, what);
	endtask : rd

	task automatic loops(input logic [3:0] p, input logic [3:0] f);
		@(posedge sys_clk);
		lp <= p;
		lf <= f;
	endtask : loops

	initial begin
		repeat (12) @(posedge sys_clk);
		resetn <= 1'b1;
		cyc(2);
		// Reset state and register access
		chk({12'h000, prim_out}, 16'h000f, "prim after reset");
		wr(`LD_A_DLY_BASE, 16'h00ff);
		rd(`LD_A_DLY_BASE, 16'h00ff, "delay full scale");
		wr(`LD_A_PMAP_BASE + 8'h3, 16'h0100);
		rd(`LD_A_PMAP_BASE + 8'h3, 16'h0000, "health to primary");
		wr(`LD_A_AMAP_BASE + 8'h3, 16'h0100);
		rd(`LD_A_AMAP_BASE + 8'h3, 16'h0100, "health to aux");
		rd(8'h40, 16'h0000, "unmapped read");
		$display("test regs done");

		// Mapping: OR of sources, aux routes, health aux only
		wr(`LD_A_PMAP_BASE + 8'h1, 16'h0012);
		wr(`LD_A_AMAP_BASE + 8'h2, 16'h0020);
		@(posedge sys_clk);
		vin <= 4'h3;
		hok <= 1'b0;
		cyc(6);
		chk({12'h000, prim_out}, 16'h000d, "vital in on primary");
		chk({12'h000, aux_out}, 16'h0003, "aux routes");
		@(posedge sys_clk);
		vin <= 4'h0;
		hok <= 1'b1;
		loops(4'h2, 4'h0);
		cyc(6);
		chk({12'h000, prim_out}, 16'h000d, "loop on primary");
		loops(4'h0, 4'h0);
		cyc(6);
		chk({12'h000, prim_out}, 16'h000f, "all clear");
		$display("test mapping done");

		// Delay and extension with retrigger on output 1
		wr(`LD_A_DLY_BASE, 16'h0003);
		wr(`LD_A_EXT_BASE, 16'h0003);
		wr(`LD_A_PMAP_BASE, 16'h0001);
		wr(`LD_A_AMAP_BASE, 16'h0001);
		loops(4'h1, 4'h0);
		cyc(4);
		chk({15'h0000, prim_out[0]}, 16'h0001, "delay running");
		chk({12'h000, aux_out}, 16'h000e, "aux without delay");
		cyc(21);
		chk({12'h000, prim_out}, 16'h000e, "delay expired");
		chk({12'h000, aux_out}, 16'h000e, "aux free of delay");
		rd(`LD_A_OUTS, 16'h00ee, "outputs register");
		loops(4'h0, 4'h0);
		cyc(4);
		chk({15'h0000, prim_out[0]}, 16'h0000, "extension running");
		chk({12'h000, aux_out}, 16'h000f, "aux free of extension");
		loops(4'h1, 4'h0);
		cyc(6);
		chk({15'h0000, prim_out[0]}, 16'h0000, "call in extension");
		loops(4'h0, 4'h0);
		cyc(8);
		chk({15'h0000, prim_out[0]}, 16'h0000, "extension reloaded");
		cyc(20);
		chk({15'h0000, prim_out[0]}, 16'h0001, "extension expired");
		chk(n_drop0, 16'h0001, "single drop");
		$display("test timers done");

		// Island mode
		wr(`LD_A_DLY_BASE, 16'h0000);
		wr(`LD_A_EXT_BASE, 16'h0000);
		wr(`LD_A_MODE_CMD, 16'h000b);
		rd(`LD_A_STATUS, 16'h0001, "island detector wide");
		wr(`LD_A_MODE_CMD, 16'h000c);
		#1;
		seen = warn_buzz;
		cyc(1);
		chk({14'h0000, seen, warn_buzz}, 16'h0002, "buzz on conflict");
		rd(`LD_A_STATUS, 16'h0001, "pair refused");
		loops(4'h2, 4'h0);
		cyc(6);
		chk({15'h0000, island_active}, 16'h0000, "main loop alone");
		loops(4'h1, 4'h0);
		cyc(4);
		chk({11'h000, island_active, aux_out}, 16'h001e, "armed");
		loops(4'h2, 4'h0);
		cyc(4);
		loops(4'h4, 4'h0);
		cyc(4);
		chk({11'h000, island_active, aux_out}, 16'h001e, "crossing");
		loops(4'h0, 4'h0);
		cyc(4);
		chk({11'h000, island_active, aux_out}, 16'h000f, "cleared");
		wr(`LD_A_MODE_CMD, 16'h0000);
		$display("test island done");

		// Paired direction mode on channels 1 and 2
		wr(`LD_A_PMAP_BASE + 8'h1, 16'h0002);
		wr(`LD_A_EXT_BASE + 8'h1, 16'h0003);
		wr(`LD_A_MODE_CMD, 16'h000c);
		rd(`LD_A_STATUS, 16'h0002, "pair both channels");
		wr(`LD_A_MODE_CMD, 16'h000f);
		rd(`LD_A_STATUS, 16'h0006, "pair of channels 3 and 4");
		wr(`LD_A_MODE_CMD, 16'h0009);
		#1;
		chk({15'h0000, warn_buzz}, 16'h0001, "island refused in pair mode");
		rd(`LD_A_STATUS, 16'h0006, "island stays off");
		wr(`LD_A_MODE_CMD, 16'h0006);
		rd(`LD_A_STATUS, 16'h0002, "pair 3/4 off");
		loops(4'h1, 4'h0);
		cyc(5);
		chk({12'h000, prim_out}, 16'h000f, "first pends");
		loops(4'h3, 4'h0);
		cyc(5);
		chk({12'h000, prim_out}, 16'h000d, "second calls");
		loops(4'h2, 4'h0);
		cyc(5);
		chk({12'h000, prim_out}, 16'h000d, "last holds");
		loops(4'h0, 4'h0);
		cyc(5);
		chk({12'h000, prim_out}, 16'h000d, "pair keeps extension");
		cyc(15);
		chk({12'h000, prim_out}, 16'h000f, "both clear");
		wr(`LD_A_EXT_BASE + 8'h1, 16'h0000);
		loops(4'h0, 4'h1);
		cyc(5);
		chk({12'h000, prim_out}, 16'h000c, "failure both on");
		loops(4'h0, 4'h0);
		cyc(5);
		chk({12'h000, prim_out}, 16'h000f, "failure cleared");
		// Opposite travel direction: channel 2 first, channel 1 calls
		loops(4'h2, 4'h0);
		cyc(5);
		chk({12'h000, prim_out}, 16'h000f, "reverse first pends");
		loops(4'h3, 4'h0);
		cyc(5);
		chk({8'h00, aux_out, prim_out}, 16'h00ee, "reverse second calls");
		loops(4'h1, 4'h0);
		cyc(5);
		chk({8'h00, aux_out, prim_out}, 16'h00ee, "reverse last holds");
		loops(4'h0, 4'h0);
		cyc(5);
		chk({8'h00, aux_out, prim_out}, 16'h00ff, "reverse both clear");
		$display("test pair done");
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
